// *** logic/rsc_consts.svh ***
// Addresses, fields, reset values and timing of the reference control block
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ==========================================================================
// Register addresses
`define RSC_A_CUR_TRIM 8'h09
`define RSC_A_CLOCK_RATE_MHZ_CODE 8'h0b
`define RSC_A_SWING 8'h2c
`define RSC_A_GCTRL 8'h75
`define RSC_A_RATE 8'h76
`define RSC_A_IRQ_EN 8'h77
`define RSC_A_IRQ_MASK 8'h78
`define RSC_A_RESET_CMD 8'h79
`define RSC_A_LOOP_DIV 8'h7a
`define RSC_A_DEV_STAT 8'h83
`define RSC_A_GCTRL_RD 8'hc5
`define RSC_A_RATE_RD 8'hc6
`define RSC_A_IRQ_EN_RD 8'hc7
`define RSC_A_IRQ_MASK_RD 8'hc8
`define RSC_A_IRQ_STAT 8'hc9
`define RSC_A_LOOP_DIV_RD 8'hca
`define RSC_A_SWING_RD 8'hd6
`define RSC_A_CUR_TRIM_RD 8'hd9
`define RSC_A_CLOCK_RATE_MHZ_CODE_RD 8'hdb

// ==========================================================================
// Reset values and field masks
`define RSC_RST_GCTRL 8'h00
`define RSC_RST_RATE 8'h26
`define RSC_RST_IRQ 8'h00
`define RSC_RST_LOOP_DIV 8'h1f
`define RSC_RST_CUR_TRIM 8'h10
`define RSC_RST_CLOCK_RATE_MHZ_CODE 16'h0102
`define RSC_RST_SWING 8'h20
`define RSC_M_GCTRL 8'h3f
`define RSC_M_RATE 8'h3f
`define RSC_M_IRQ 8'h07
`define RSC_M_LOOP_DIV 8'h7f
`define RSC_M_CUR_TRIM 8'h1f
`define RSC_M_SWING 8'h3f
`define RSC_M_CLOCK_RATE_MHZ_CODE 16'h01ff
`define RSC_M_DEV_STAT 8'h0f

// ==========================================================================
// Bit positions
`define RSC_B_MCLK 0
`define RSC_B_LOOP 1
`define RSC_B_CAL 2
`define RSC_B_OSC 3
`define RSC_B_LO_OUT 4
`define RSC_B_CLK_OUT 5
`define RSC_I_READY 0
`define RSC_I_RETUNE 1
`define RSC_I_CALDONE 2
`define RSC_B_TIMEOUT 15

// ==========================================================================
// Timing
`define RSC_CAL_TIMEOUT_CYC 16'd4000

`endif

// *** logic/rsc_pkg.sv ***
// Types shared by the reference control block
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_IDLE,
    RSC_RUN,
    RSC_DONE
  } rsc_cal_state_t;

  // Results reported by the analogue calibration engine
  typedef struct packed {
    logic [4:0] cur_trim;
    logic [8:0] clock_rate_mhz_code;
    logic [5:0] swing;
    logic timeout;
  } rsc_cal_result_t;

  // Analogue control outputs
  typedef struct packed {
    logic mclk_en;
    logic loop_en;
    logic osc_en;
    logic lo_out_en;
    logic clk_out_en;
  } rsc_ctrl_t;
endpackage

// *** logic/rsc_regs.sv ***
// Reference section control and status register bank
`timescale 1ns/10ps
`include "rsc_consts.svh"

module rsc_regs
  import rsc_pkg::*;
#(
  parameter int unsigned CAL_TIMEOUT = `RSC_CAL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Serial register bus, decoded into word accesses
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  // Analogue side events and results
  input wire logic clk_ready_evt,
  input wire logic cal_finish,
  input wire rsc_cal_result_t cal_result,
  input wire logic [3:0] osc_indicators,
  // Controls to the analogue side
  output rsc_ctrl_t ctrl,
  output logic cal_start,
  output logic [5:0] clock_rate_mhz,
  output logic [6:0] loop_divide_value,
  output logic [4:0] cur_trim,
  output logic [8:0] clock_rate_mhz_code,
  output logic [5:0] swing_code,
  output logic interrupt_request_low
);

  // The run counter is 16 bits and must be able to reach the limit
  if (CAL_TIMEOUT < 1 || CAL_TIMEOUT > 65535) begin : g_bad_timeout
    $error("CAL_TIMEOUT out of range");
  end

  // ========================================================================
  // Storage
  logic [7:0] gctrl_q;
  logic [7:0] rate_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_stat_q;
  logic [7:0] loop_div_q;
  logic [7:0] cur_trim_q;
  logic [15:0] clock_rate_mhz_q;
  logic [7:0] swing_q;
  logic [3:0] ind_s1_q;
  logic [3:0] ind_s2_q;
  logic [3:0] ind_s3_q;
  logic [3:0] ind_q;
  logic [2:0] ready_sync_q;
  logic ready_prev_q;
  rsc_cal_state_t cal_st_q;
  logic [15:0] cal_cnt_q;
  logic [15:0] rdata_q;

  logic soft_rst;
  logic wr_gctrl;
  logic cal_trig;
  logic cal_end;
  logic cal_to;
  logic cal_abort;
  logic [7:0] evt;
  logic [7:0] latch;
  logic stat_rd;

  assign soft_rst = wr_stb && addr == `RSC_A_RESET_CMD;
  assign wr_gctrl = wr_stb && addr == `RSC_A_GCTRL;
  // Trigger honoured only with loop and clock bits in the same write
  assign cal_trig = wr_gctrl && wdata[`RSC_B_CAL] && wdata[`RSC_B_LOOP]
    && wdata[`RSC_B_MCLK] && cal_st_q != RSC_RUN;
  // A write that drops clock or loop stops a running calibration at once
  assign cal_abort = wr_gctrl && !(wdata[`RSC_B_MCLK] && wdata[`RSC_B_LOOP]);
  assign cal_to = cal_st_q == RSC_RUN
    && cal_cnt_q == 16'(CAL_TIMEOUT);
  assign cal_end = cal_st_q == RSC_RUN && (cal_finish || cal_to);
  assign stat_rd = rd_stb && addr == `RSC_A_IRQ_STAT;

  // ========================================================================
  // Events: clock ready from the analogue side, debounced into this domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_sync_q <= 3'h0;
      ready_prev_q <= 1'b0;
    end else begin
      ready_sync_q <= {ready_sync_q[1:0], clk_ready_evt};
      if (ready_sync_q[2] == ready_sync_q[1]) begin
        ready_prev_q <= ready_sync_q[2];
      end
    end
  end

  always_comb begin
    evt = 8'h00;
    evt[`RSC_I_READY] = ready_sync_q[2] && ready_sync_q[1] && !ready_prev_q
      && gctrl_q[`RSC_B_MCLK];
    evt[`RSC_I_CALDONE] = cal_end;
    evt[`RSC_I_RETUNE] = cal_to || (cal_end && cal_result.timeout);
  end

  assign latch = evt & irq_en_q & `RSC_M_IRQ;

  // ========================================================================
  // Control register and calibration bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gctrl_q <= `RSC_RST_GCTRL;
    end else if (soft_rst) begin
      gctrl_q <= `RSC_RST_GCTRL;
    end else if (wr_gctrl) begin
      gctrl_q <= wdata[7:0] & `RSC_M_GCTRL & ~(8'h01 << `RSC_B_CAL);
      gctrl_q[`RSC_B_CAL] <= cal_trig
        || (cal_st_q == RSC_RUN && !cal_end && !cal_abort);
    end else if (cal_end) begin
      gctrl_q[`RSC_B_CAL] <= 1'b0;
    end
  end

  // ========================================================================
  // Calibration sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_st_q <= RSC_IDLE;
      cal_cnt_q <= 16'h0000;
    end else if (soft_rst || cal_abort || !gctrl_q[`RSC_B_MCLK]
        || !gctrl_q[`RSC_B_LOOP]) begin
      cal_st_q <= cal_trig ? RSC_RUN : RSC_IDLE;
      cal_cnt_q <= 16'h0000;
    end else begin
      unique case (cal_st_q)
        RSC_IDLE: begin
          if (cal_trig) begin
            cal_st_q <= RSC_RUN;
          end
          cal_cnt_q <= 16'h0000;
        end
        RSC_RUN: begin
          cal_cnt_q <= cal_cnt_q + 16'h0001;
          if (cal_end) begin
            cal_st_q <= RSC_DONE;
          end
        end
        RSC_DONE: begin
          cal_st_q <= cal_trig ? RSC_RUN : RSC_IDLE;
          cal_cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Plain write registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_q <= `RSC_RST_RATE;
      irq_mask_q <= `RSC_RST_IRQ;
      loop_div_q <= `RSC_RST_LOOP_DIV;
    end else if (soft_rst) begin
      rate_q <= `RSC_RST_RATE;
      irq_mask_q <= `RSC_RST_IRQ;
      loop_div_q <= `RSC_RST_LOOP_DIV;
    end else if (wr_stb) begin
      // Writes accepted regardless of main clock enable
      unique case (addr)
        `RSC_A_RATE: rate_q <= wdata[7:0] & `RSC_M_RATE;
        `RSC_A_IRQ_MASK: irq_mask_q <= wdata[7:0] & `RSC_M_IRQ;
        `RSC_A_LOOP_DIV: loop_div_q <= wdata[7:0] & `RSC_M_LOOP_DIV;
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Interrupt enable, status and request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_q <= `RSC_RST_IRQ;
    end else if (soft_rst) begin
      irq_en_q <= `RSC_RST_IRQ;
    end else if (wr_stb && addr == `RSC_A_IRQ_EN) begin
      irq_en_q <= wdata[7:0] & `RSC_M_IRQ & ~latch;
    end else begin
      irq_en_q <= irq_en_q & ~latch;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 8'h00;
    end else if (soft_rst) begin
      irq_stat_q <= 8'h00;
    end else if (stat_rd) begin
      irq_stat_q <= latch;
    end else begin
      irq_stat_q <= irq_stat_q | latch;
    end
  end

  assign interrupt_request_low = ~|(irq_stat_q & irq_mask_q);

  // ========================================================================
  // Calibration codes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_trim_q <= `RSC_RST_CUR_TRIM;
      clock_rate_mhz_q <= `RSC_RST_CLOCK_RATE_MHZ_CODE;
      swing_q <= `RSC_RST_SWING;
    end else if (soft_rst) begin
      cur_trim_q <= `RSC_RST_CUR_TRIM;
      clock_rate_mhz_q <= `RSC_RST_CLOCK_RATE_MHZ_CODE;
      swing_q <= `RSC_RST_SWING;
    end else begin
      if (wr_stb && addr == `RSC_A_CUR_TRIM) begin
        cur_trim_q <= wdata[7:0] & `RSC_M_CUR_TRIM;
      end
      if (wr_stb && addr == `RSC_A_SWING) begin
        swing_q <= wdata[7:0] & `RSC_M_SWING;
      end
      if (wr_stb && addr == `RSC_A_CLOCK_RATE_MHZ_CODE) begin
        clock_rate_mhz_q <= wdata & `RSC_M_CLOCK_RATE_MHZ_CODE;
      end else if (cal_trig) begin
        clock_rate_mhz_q[`RSC_B_TIMEOUT] <= 1'b0;
      end
      if (cal_end) begin
        cur_trim_q <= {3'h0, cal_result.cur_trim};
        swing_q <= {2'h0, cal_result.swing};
        clock_rate_mhz_q <= {cal_to || cal_result.timeout, 6'h00,
          cal_result.clock_rate_mhz_code};
      end
    end
  end

  // ========================================================================
  // Oscillator indicators from the analogue side
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_s1_q <= 4'h0;
      ind_s2_q <= 4'h0;
      ind_s3_q <= 4'h0;
      ind_q <= 4'h0;
    end else begin
      ind_s1_q <= osc_indicators;
      ind_s2_q <= ind_s1_q;
      ind_s3_q <= ind_s2_q;
      if (ind_s2_q == ind_s3_q) begin
        ind_q <= ind_s3_q;
      end
    end
  end

  // ========================================================================
  // Readback
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd_stb) begin
      unique case (addr)
        `RSC_A_GCTRL_RD: rdata_q <= {8'h00, gctrl_q};
        `RSC_A_RATE_RD: rdata_q <= {8'h00, rate_q};
        `RSC_A_IRQ_EN_RD: rdata_q <= {8'h00, irq_en_q};
        `RSC_A_IRQ_MASK_RD: rdata_q <= {8'h00, irq_mask_q};
        `RSC_A_IRQ_STAT: rdata_q <= {8'h00, irq_stat_q};
        `RSC_A_LOOP_DIV_RD: rdata_q <= {8'h00, loop_div_q};
        `RSC_A_DEV_STAT: rdata_q <= {12'h000, ind_q};
        `RSC_A_CUR_TRIM_RD: rdata_q <= {8'h00, cur_trim_q};
        `RSC_A_SWING_RD: rdata_q <= {8'h00, swing_q};
        `RSC_A_CLOCK_RATE_MHZ_CODE_RD: rdata_q <= clock_rate_mhz_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign rdata = rdata_q;

  // ========================================================================
  // Analogue controls; the ctrl enables gated by the main clock enable, the code outputs not
  always_comb begin
    ctrl.mclk_en = gctrl_q[`RSC_B_MCLK];
    ctrl.loop_en = gctrl_q[`RSC_B_MCLK] && gctrl_q[`RSC_B_LOOP];
    ctrl.osc_en = gctrl_q[`RSC_B_MCLK] && gctrl_q[`RSC_B_OSC];
    ctrl.lo_out_en = gctrl_q[`RSC_B_MCLK] && gctrl_q[`RSC_B_LO_OUT];
    ctrl.clk_out_en = gctrl_q[`RSC_B_MCLK] && gctrl_q[`RSC_B_CLK_OUT];
  end

  assign cal_start = cal_st_q == RSC_RUN;
  assign clock_rate_mhz = rate_q[5:0];
  assign loop_divide_value = loop_div_q[6:0];
  assign cur_trim = cur_trim_q[4:0];
  assign clock_rate_mhz_code = clock_rate_mhz_q[8:0];
  assign swing_code = swing_q[5:0];

endmodule

// *** tb/rsc_analog_model.sv ***
// Behavioural model of the analogue clock buffer and calibration engine
`timescale 1ns/10ps
module rsc_analog_model
  import rsc_pkg::*;
#(
  parameter int unsigned FINISH_CYC = 6,
  parameter rsc_cal_result_t RESULT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Controls from the block
  input wire rsc_ctrl_t ctrl,
  input wire logic cal_start,
  input wire logic stall,
  // Events back to the block
  output logic clk_ready_evt,
  output logic cal_finish,
  output rsc_cal_result_t cal_result,
  output logic [3:0] osc_indicators
);
  logic [3:0] ready_q;
  logic [7:0] run_q;
  // Buffer settles a few cycles after the main clock comes on
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 4'h0;
    end else begin
      ready_q <= {ready_q[2:0], ctrl.mclk_en};
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 8'h00;
    end else if (cal_start && !stall) begin
      run_q <= run_q + 8'h01;
    end else begin
      run_q <= 8'h00;
    end
  end
  assign clk_ready_evt = ready_q[3];
  // A stalled engine never reports, forcing the block's timeout
  assign cal_finish = cal_start && !stall && run_q == 8'(FINISH_CYC);
  // Result is only valid with the finish pulse
  assign cal_result = cal_finish ? RESULT : ~RESULT;
  assign osc_indicators = 4'h5;
endmodule

// *** tb/rsc_regs_chk.sv ***
// Port assertions for the reference control register bank
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_regs_chk
  import rsc_pkg::*;
#(
  parameter int unsigned CAL_TIMEOUT = 4000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  // Analogue side
  input wire logic clk_ready_evt,
  input wire logic cal_finish,
  input wire rsc_cal_result_t cal_result,
  input wire logic [3:0] osc_indicators,
  input wire rsc_ctrl_t ctrl,
  input wire logic cal_start,
  input wire logic [5:0] clock_rate_mhz,
  input wire logic [6:0] loop_divide_value,
  input wire logic [4:0] cur_trim,
  input wire logic [8:0] clock_rate_mhz_code,
  input wire logic [5:0] swing_code,
  input wire logic interrupt_request_low
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic wr_ctl = wr_stb && addr == `RSC_A_GCTRL;
  // ====
  // Properties
  chk_clock_gates_all:
  assert property (!ctrl.mclk_en |-> ctrl == '0)
    else $error("control active without main clock");
  chk_ctrl_follows_write:
  assert property (wr_ctl |=> ctrl.mclk_en == $past(wdata[0])
    && ctrl.loop_en == ($past(wdata[1]) && $past(wdata[0]))
    && ctrl.osc_en == ($past(wdata[3]) && $past(wdata[0])))
    else $error("control outputs differ from write");
  chk_cal_trigger:
  assert property (wr_ctl && wdata[2:0] == 3'h7 && !cal_start |=> cal_start)
    else $error("calibration did not start");
  chk_cal_refused:
  assert property (wr_ctl && wdata[1:0] != 2'h3 |=> !cal_start)
    else $error("calibration ran without loop enabled");
  chk_cal_ends:
  assert property (cal_start && cal_finish |=> !cal_start)
    else $error("calibration kept running after finish");
  chk_cal_loads_codes:
  assert property (cal_start && cal_finish |=>
    cur_trim == $past(cal_result.cur_trim)
    && clock_rate_mhz_code == $past(cal_result.clock_rate_mhz_code)
    && swing_code == $past(cal_result.swing))
    else $error("calibration codes not loaded");
  chk_rate_write:
  assert property (wr_stb && addr == `RSC_A_RATE |=>
    clock_rate_mhz == $past(wdata[5:0]))
    else $error("clock rate field wrong");
  chk_div_readback:
  assert property (rd_stb && addr == `RSC_A_LOOP_DIV_RD |=>
    rdata == {9'h000, $past(loop_divide_value)})
    else $error("divider readback wrong");
  chk_status_upper:
  assert property (rd_stb && addr == `RSC_A_IRQ_STAT |=> rdata[15:3] == '0)
    else $error("status unused bits set");
  chk_reset_cmd:
  assert property (wr_stb && addr == `RSC_A_RESET_CMD |=> ctrl == '0
    && clock_rate_mhz == 6'h26 && loop_divide_value == 7'h1f
    && interrupt_request_low)
    else $error("reset command left state");
endmodule

bind rsc_regs rsc_regs_chk #(.CAL_TIMEOUT(CAL_TIMEOUT)) u_rsc_regs_chk (
  .core_clk(core_clk), .arst_n(arst_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .addr(addr), .wdata(wdata), .rdata(rdata), .clk_ready_evt(clk_ready_evt),
  .cal_finish(cal_finish), .cal_result(cal_result),
  .osc_indicators(osc_indicators), .ctrl(ctrl), .cal_start(cal_start),
  .clock_rate_mhz(clock_rate_mhz), .loop_divide_value(loop_divide_value),
  .cur_trim(cur_trim), .clock_rate_mhz_code(clock_rate_mhz_code), .swing_code(swing_code),
  .interrupt_request_low(interrupt_request_low)
);

// *** tb/tb_rsc_regs.sv ***
// Self-checking bench for the reference control register bank
`timescale 1ns/10ps
module tb_rsc_regs;
  localparam int unsigned TOUT = 20;
  localparam rsc_pkg::rsc_cal_result_t RES = '{5'h0a, 9'h155, 6'h2b, 1'b0};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic stall = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic clk_ready_evt, cal_finish, cal_start, interrupt_request_low;
  rsc_pkg::rsc_cal_result_t cal_result;
  rsc_pkg::rsc_ctrl_t ctrl;
  logic [3:0] osc_indicators;
  logic [5:0] clock_rate_mhz, swing_code;
  logic [6:0] loop_divide_value;
  logic [4:0] cur_trim;
  logic [8:0] clock_rate_mhz_code;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  // Write address, write data, read address, expected; ff writes nothing
  logic [47:0] rows [0:20] = '{
    48'hff0000c50000, 48'hff0000c60026, 48'hff0000c70000,
    48'hff0000c80000, 48'hff0000c90000, 48'hff0000ca001f,
    48'hff0000d90010, 48'hff0000d60020, 48'hff0000db0102,
    48'hff0000830005, 48'h7600e8c60028, 48'h7a0085ca0005,
    48'h7a0004ca0004, 48'h7700ffc70007, 48'h7800ffc80007,
    48'h0900ffd9001f, 48'h2c00ffd6003f, 48'h0bffffdb01ff,
    48'hc60011c60028, 48'h500011500000, 48'h7500c8c50008};

  rsc_regs #(.CAL_TIMEOUT(TOUT)) u_rsc_regs (
    .core_clk(core_clk), .arst_n(arst_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .addr(addr), .wdata(wdata), .rdata(rdata), .clk_ready_evt(clk_ready_evt),
    .cal_finish(cal_finish), .cal_result(cal_result),
    .osc_indicators(osc_indicators), .ctrl(ctrl), .cal_start(cal_start),
    .clock_rate_mhz(clock_rate_mhz), .loop_divide_value(loop_divide_value),
    .cur_trim(cur_trim), .clock_rate_mhz_code(clock_rate_mhz_code), .swing_code(swing_code),
    .interrupt_request_low(interrupt_request_low));
  rsc_analog_model #(.RESULT(RES)) u_rsc_analog_model (
    .core_clk(core_clk), .arst_n(arst_n), .ctrl(ctrl), .cal_start(cal_start),
    .stall(stall), .clk_ready_evt(clk_ready_evt), .cal_finish(cal_finish),
    .cal_result(cal_result), .osc_indicators(osc_indicators));

  // ====
  // Tasks
  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    wr_stb = 1'b1;
    addr = a;
    wdata = d;
    @(negedge core_clk);
    wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
      input logic [15:0] msk = 16'hffff);
    @(negedge core_clk);
    rd_stb = 1'b1;
    addr = a;
    @(negedge core_clk);
    rd_stb = 1'b0;
    check($sformatf("read %h", a), exp, rdata & msk);
  endtask
  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      wr(rows[i][47:40], rows[i][39:24]);
      rd(rows[i][23:16], rows[i][15:0]);
    end
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ====
  // Clock, timeout and sequence
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    run_rows(0, 9);
    $display("defaults done");
    run_rows(10, 20);
    $display("access table done");
    wr(8'h75, 16'h0007);
    rd(8'hc5, 16'h0007);
    repeat (20) @(negedge core_clk);
    rd(8'hc5, 16'h0003);
    rd(8'hd9, {11'h000, RES.cur_trim});
    rd(8'hdb, {7'h00, RES.clock_rate_mhz_code});
    rd(8'hd6, {10'h000, RES.swing});
    check("irq", 16'h0000, {15'h0000, interrupt_request_low});
    rd(8'hc7, 16'h0002);
    rd(8'hc9, 16'h0005);
    rd(8'hc9, 16'h0000);
    check("irq", 16'h0001, {15'h0000, interrupt_request_low});
    $display("calibration done");
    stall = 1'b1;
    wr(8'h77, 16'h0006);
    wr(8'h75, 16'h0007);
    repeat (TOUT + 10) @(negedge core_clk);
    stall = 1'b0;
    rd(8'hdb, 16'h8000, 16'h8000);
    rd(8'hc9, 16'h0006);
    wr(8'h0b, 16'h0055);
    rd(8'hdb, 16'h0055);
    $display("timeout done");
    wr(8'h75, 16'h003e);
    check("ctrl", 16'h0000, {11'h000, ctrl});
    check("cal start", 16'h0000, {15'h0000, cal_start});
    wr(8'h79, 16'h0000);
    run_rows(0, 9);
    $display("reset command done");
    wr(8'h77, 16'h0004);
    wr(8'h75, 16'h0007);
    repeat (5) @(negedge core_clk);
    rd(8'hc9, 16'h0000);
    rd(8'hc9, 16'h0004);
    $display("coincident read done");
    @(negedge core_clk);
    arst_n = 1'b0;
    @(negedge core_clk);
    arst_n = 1'b1;
    rd(8'hc5, 16'h0000);
    rd(8'hdb, 16'h0102);
    check("irq", 16'h0001, {15'h0000, interrupt_request_low});
    $display("async reset done");
    results();
  end
endmodule
